// *** src/rlsc_consts.svh ***
// constants for the relay latch and safety control block
`ifndef RLSC_CONSTS_SVH
`define RLSC_CONSTS_SVH
`define RLSC_OFF_MUX      12'h000
`define RLSC_OFF_DAC      12'h004
`define RLSC_OFF_GEN      12'h008
`define RLSC_OFF_SAFE     12'h00c
`define RLSC_OFF_CTRL     12'h010
`define RLSC_OFF_STATUS   12'h014
`define RLSC_MUX_W        4
`define RLSC_DAC_W        8
`define RLSC_GEN_W        14
`define RLSC_SAFE_W       8
`define RLSC_RST_MUX      4'h0
`define RLSC_RST_DAC      8'h00
`define RLSC_RST_GEN      14'h0000
`define RLSC_RST_SAFE     8'h00
// general latch fields
`define RLSC_GEN_CUR_GUARD   0
`define RLSC_GEN_LSENSE_SBY  1
`define RLSC_GEN_DIRECT_CAL0 2
`define RLSC_GEN_DIRECT_CAL1 3
`define RLSC_GEN_BAND_LSB    10
// safety latch fields
`define RLSC_SAFE_OUT_RELAY  0
`define RLSC_SAFE_RSENSE     1
`define RLSC_SAFE_LSENSE     2
`define RLSC_SAFE_RETURN     3
`define RLSC_SAFE_SENSE_SW   4
`define RLSC_SAFE_CLAMP      5
`define RLSC_SAFE_HV_ON      6
// control register bits
`define RLSC_CTRL_CLEAR      0
// status bits
`define RLSC_ST_COMPARE      0
`define RLSC_ST_CABLE_OK     1
`define RLSC_ST_CAL_EN       2
`define RLSC_ST_HV_FAULT     3
`define RLSC_ST_SAFE_HELD    4
`endif

// *** src/rlsc_pkg.sv ***
// types for the relay latch and safety control block
package rlsc_pkg;
  typedef enum logic [1:0] {RLSC_IDLE, RLSC_ACCESS} rlsc_apb_state_t;
  // first member is the top bit: band at 13:10, guard at bit 0
  typedef struct packed {
    logic [3:0]  band;
    logic [5:0]  spare;
    logic [1:0]  direct_cal;
    logic        lsense_sby;
    logic        cur_guard;
  } rlsc_gen_t;
endpackage

// *** src/rlsc_sync_if.sv ***
// carrier for synchronised pin levels
`timescale 1ns/10ps
interface rlsc_sync_if;
  logic cable_ok;
  logic hv_overcurrent;
  logic compare;
  logic cal_enable;
  modport src (output cable_ok, output hv_overcurrent, output compare,
               output cal_enable);
  modport dst (input cable_ok, input hv_overcurrent, input compare,
               input cal_enable);
endinterface

// *** src/rlsc_pin_sync.sv ***
// three-stage synchronisers for the asynchronous status pins
`timescale 1ns/10ps
module rlsc_pin_sync
(
  // clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_rstn,
  // raw pins
  input  wire logic i_cable_ok,
  input  wire logic i_hv_overcurrent,
  input  wire logic i_compare,
  input  wire logic i_cal_enable,
  // filtered levels
  rlsc_sync_if.src  sync
);
  logic [3:0] s1;
  logic [3:0] s2;
  logic [3:0] s3;
  logic [3:0] held;

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
    begin
      s1 <= 4'h0;
      s2 <= 4'h0;
      s3 <= 4'h0;
    end
    else
    begin
      s1 <= {i_cal_enable, i_compare, i_hv_overcurrent, i_cable_ok};
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a change counts only once stages two and three agree
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
      held <= 4'h0;
    else
    begin
      for (int i = 0; i < 4; i++)
        if (s2[i] == s3[i])
          held[i] <= s3[i];
    end
  end

  assign sync.cable_ok       = held[0];
  assign sync.hv_overcurrent = held[1];
  assign sync.compare        = held[2];
  assign sync.cal_enable     = held[3];
endmodule

// *** src/rlsc_top.sv ***
// relay latches, monitor latches and safety clear logic with apb access
// Behaviour
// - normal: mux feeds comparator only
// - calibration: mux routed to precision return
// - mux select latched until rewritten
// - dac code in own latch, always applied
// - comparator result readable as status bit
// - serial link receive and transmit lines
// - cable-connected status bit for processor
// - presence line pulled while powered
// - two relay latches drive coils directly
// - processor clear empties both relay latches
// - general latch: six, four, four-band relays
// - external high-voltage relays on safety latch
// - safety clear is or of three
// - missing cable clears safety latch
// - overcurrent shuts supply, clears safety latch
// - safety latch drives clamp and supply enable
// - safety bit enables sense isolation switch
// - calibration-enable contact readable as status
// - current guard relay per current path
// - standby: local-sense relay closed
// - direct-drive relays closed only in calibration; here they follow general latch bits 3:2 whatever the cal-enable contact reads
// - operate: output/remote; else local sense
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/10ps
`include "rlsc_consts.svh"
module rlsc_top
  import rlsc_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  // clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_rstn,
  // apb slave
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic      [31:0]       o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  // serial link
  input  wire logic              i_link_receive_line,
  output logic                   o_link_transmit_line,
  output logic                   o_link_rx_data,
  input  wire logic              i_link_tx_data,
  output logic                   o_amp_present_n,
  // status pins
  input  wire logic              i_link_cable_ok,
  input  wire logic              i_hv_overcurrent,
  input  wire logic              i_monitor_compare,
  input  wire logic              i_cal_enable_contact,
  // monitor section
  output logic [3:0]             o_mux_select_latch,
  output logic [7:0]             o_dac_code_latch,
  output logic                   o_monitor_compare_out,
  output logic                   o_precision_return_relay,
  output logic                   o_sense_isolation_switch,
  // relay drives
  output logic [13:0]            o_general_relay_latch,
  output logic [3:0]             o_band_relay_drive,
  output logic                   o_current_guard_relay,
  output logic                   o_local_sense_relay_standby,
  output logic [1:0]             o_direct_cal_relay,
  output logic [7:0]             o_safety_relay_latch,
  output logic                   o_output_relay,
  output logic                   o_remote_sense_relay,
  output logic                   o_local_sense_relay,
  output logic                   o_amp_clamp_drive,
  output logic                   o_hv_supply_enable_n,
  output logic                   o_hv_shutdown,
  output logic                   o_hv_fault_clear,
  output logic                   o_link_cable_missing
);
  rlsc_sync_if sync ();

  rlsc_pin_sync u_sync (
    .i_clk_sys        (i_clk_sys),
    .i_rstn           (i_rstn),
    .i_cable_ok       (i_link_cable_ok),
    .i_hv_overcurrent (i_hv_overcurrent),
    .i_compare        (i_monitor_compare),
    .i_cal_enable     (i_cal_enable_contact),
    .sync             (sync)
  );

  rlsc_apb_state_t apb_state;
  logic [3:0]      mux_sel;
  logic [7:0]      dac_code;
  rlsc_gen_t       gen;
  logic [7:0]      safe;
  logic            clear_cmd;
  logic            hv_fault;
  logic            composite_clr;
  logic            wr_en;
  logic            rd_en;
  logic            addr_ok;
  logic [31:0]     next_rdata;
  logic [2:0]      rx_sync;
  logic [ADDR_W-1:0] off_mux;
  logic [ADDR_W-1:0] off_dac;
  logic [ADDR_W-1:0] off_gen;
  logic [ADDR_W-1:0] off_safe;
  logic [ADDR_W-1:0] off_ctrl;
  logic [ADDR_W-1:0] off_stat;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  assign off_mux  = ADDR_W'(`RLSC_OFF_MUX);
  assign off_dac  = ADDR_W'(`RLSC_OFF_DAC);
  assign off_gen  = ADDR_W'(`RLSC_OFF_GEN);
  assign off_safe = ADDR_W'(`RLSC_OFF_SAFE);
  assign off_ctrl = ADDR_W'(`RLSC_OFF_CTRL);
  assign off_stat = ADDR_W'(`RLSC_OFF_STATUS);

  // two wait states: access phase seen, access state, then pready
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
      apb_state <= RLSC_IDLE;
    else
    begin
      case (apb_state)
        RLSC_IDLE:
          if (i_psel && i_penable && !o_pready)
            apb_state <= RLSC_ACCESS;
        RLSC_ACCESS:
          apb_state <= RLSC_IDLE;
        default:
          apb_state <= RLSC_IDLE;
      endcase
    end
  end

  assign addr_ok = hit(i_paddr, off_mux) || hit(i_paddr, off_dac) ||
                   hit(i_paddr, off_gen) || hit(i_paddr, off_safe) ||
                   hit(i_paddr, off_ctrl) || hit(i_paddr, off_stat);
  // writes land only at the edge that samples pready high
  assign wr_en   = o_pready && i_psel && i_penable && i_pwrite && addr_ok;
  assign rd_en   = (apb_state == RLSC_ACCESS) && !i_pwrite;

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
    begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end
    else
    begin
      o_pready  <= (apb_state == RLSC_ACCESS);
      o_pslverr <= (apb_state == RLSC_ACCESS) && !addr_ok;
    end
  end

  // one-cycle clear pulse from the control register
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
      clear_cmd <= 1'b0;
    else
      clear_cmd <= wr_en && hit(i_paddr, off_ctrl) &&
                   i_pwdata[`RLSC_CTRL_CLEAR];
  end

  // overcurrent shuts supply; fault held while the pin stays high
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
      hv_fault <= 1'b0;
    else
      hv_fault <= sync.hv_overcurrent;
  end

  assign composite_clr = clear_cmd || !sync.cable_ok || hv_fault;

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
      mux_sel <= `RLSC_RST_MUX;
    else if (wr_en && hit(i_paddr, off_mux))
      mux_sel <= i_pwdata[`RLSC_MUX_W-1:0];
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
      dac_code <= `RLSC_RST_DAC;
    else if (wr_en && hit(i_paddr, off_dac))
      dac_code <= i_pwdata[`RLSC_DAC_W-1:0];
  end

  // general latch: processor clear only, hardware faults do not touch it
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
      gen <= `RLSC_RST_GEN;
    else if (clear_cmd)
      gen <= `RLSC_RST_GEN;
    else if (wr_en && hit(i_paddr, off_gen))
      gen <= i_pwdata[`RLSC_GEN_W-1:0];
  end

  // clear beats any write arriving in the same cycle
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
      safe <= `RLSC_RST_SAFE;
    else if (composite_clr)
      safe <= `RLSC_RST_SAFE;
    else if (wr_en && hit(i_paddr, off_safe))
      safe <= i_pwdata[`RLSC_SAFE_W-1:0];
  end

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (hit(i_paddr, off_mux))
      next_rdata[`RLSC_MUX_W-1:0] = mux_sel;
    else if (hit(i_paddr, off_dac))
      next_rdata[`RLSC_DAC_W-1:0] = dac_code;
    else if (hit(i_paddr, off_gen))
      next_rdata[`RLSC_GEN_W-1:0] = gen;
    else if (hit(i_paddr, off_safe))
      next_rdata[`RLSC_SAFE_W-1:0] = safe;
    else if (hit(i_paddr, off_stat))
    begin
      next_rdata[`RLSC_ST_COMPARE]   = sync.compare;
      next_rdata[`RLSC_ST_CABLE_OK]  = sync.cable_ok;
      next_rdata[`RLSC_ST_CAL_EN]    = sync.cal_enable;
      next_rdata[`RLSC_ST_HV_FAULT]  = hv_fault;
      next_rdata[`RLSC_ST_SAFE_HELD] = composite_clr;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
      o_prdata <= 32'h0000_0000;
    else if (rd_en)
      o_prdata <= next_rdata;
  end

  // serial link: registered pass-through both ways
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
    begin
      rx_sync              <= 3'h7;
      o_link_transmit_line <= 1'b1;
      o_link_rx_data       <= 1'b1;
      o_amp_present_n      <= 1'b1;
    end
    else
    begin
      // rx pin: three flops, taken once stages two and three agree
      rx_sync              <= {rx_sync[1:0], i_link_receive_line};
      o_link_transmit_line <= i_link_tx_data;
      if (rx_sync[1] == rx_sync[2])
        o_link_rx_data     <= rx_sync[2];
      o_amp_present_n      <= 1'b0;
    end
  end

  // monitor section drives
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
    begin
      o_mux_select_latch       <= `RLSC_RST_MUX;
      o_dac_code_latch         <= `RLSC_RST_DAC;
      o_monitor_compare_out    <= 1'b0;
      o_precision_return_relay <= 1'b0;
      o_sense_isolation_switch <= 1'b0;
    end
    else
    begin
      o_mux_select_latch       <= mux_sel;
      o_dac_code_latch         <= dac_code;
      o_monitor_compare_out    <= sync.compare;
      // return relay off means mux sees comparator only
      o_precision_return_relay <= safe[`RLSC_SAFE_RETURN];
      o_sense_isolation_switch <= safe[`RLSC_SAFE_SENSE_SW];
    end
  end

  // relay coil drives follow the latch bits directly
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
    begin
      o_general_relay_latch       <= `RLSC_RST_GEN;
      o_band_relay_drive          <= 4'h0;
      o_current_guard_relay       <= 1'b0;
      o_local_sense_relay_standby <= 1'b0;
      o_direct_cal_relay          <= 2'h0;
      o_safety_relay_latch        <= `RLSC_RST_SAFE;
      o_output_relay              <= 1'b0;
      o_remote_sense_relay        <= 1'b0;
      o_local_sense_relay         <= 1'b0;
      o_amp_clamp_drive           <= 1'b0;
      o_hv_supply_enable_n        <= 1'b1;
    end
    else
    begin
      o_general_relay_latch       <= gen;
      o_band_relay_drive          <= gen.band;
      o_current_guard_relay       <= gen.cur_guard;
      o_local_sense_relay_standby <= gen.lsense_sby;
      o_direct_cal_relay          <= gen.direct_cal;
      o_safety_relay_latch        <= safe;
      o_output_relay              <= safe[`RLSC_SAFE_OUT_RELAY];
      o_remote_sense_relay        <= safe[`RLSC_SAFE_RSENSE];
      o_local_sense_relay         <= safe[`RLSC_SAFE_LSENSE];
      o_amp_clamp_drive           <= safe[`RLSC_SAFE_CLAMP];
      o_hv_supply_enable_n        <= !safe[`RLSC_SAFE_HV_ON];
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
    begin
      o_hv_shutdown        <= 1'b0;
      o_hv_fault_clear     <= 1'b0;
      o_link_cable_missing <= 1'b0;
    end
    else
    begin
      o_hv_shutdown        <= hv_fault;
      o_hv_fault_clear     <= hv_fault;
      o_link_cable_missing <= !sync.cable_ok;
    end
  end
endmodule

// *** tb/rlsc_top_asserts.sv ***
// assertion checker bound to the relay latch and safety control block
`timescale 1ns/10ps
module rlsc_top_asserts
#(
  parameter int ADDR_W = 12
)
(
  // clock, reset and apb
  input wire logic              i_clk_sys,
  input wire logic              i_rstn,
  input wire logic              i_psel,
  input wire logic              i_penable,
  input wire logic              i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0]       i_pwdata,
  input wire logic              o_pready,
  input wire logic              o_pslverr,
  // latches and safety lines
  input wire logic              o_amp_present_n,
  input wire logic [3:0]        o_mux_select_latch,
  input wire logic [13:0]       o_general_relay_latch,
  input wire logic [7:0]        o_safety_relay_latch,
  input wire logic              o_hv_supply_enable_n,
  input wire logic              o_hv_fault_clear,
  input wire logic              o_link_cable_missing
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  logic wr_acc;
  assign wr_acc = i_psel && i_penable && i_pwrite;
  ready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("pready held too long");
  slverr_ready_a: assert property (o_pslverr |-> o_pready && i_psel)
    else $error("pslverr outside an answer");
  // clear may lag the fault line by a cycle or two
  fault_clear_a: assert property (o_hv_fault_clear [*3]
    |-> o_safety_relay_latch == 8'h00) else $error("fault left latch set");
  cable_clear_a: assert property (o_link_cable_missing [*3] |->
    o_safety_relay_latch == 8'h00) else $error("cable loss left latch set");
  presence_low_a: assert property (i_rstn [*3] |-> !o_amp_present_n)
    else $error("presence line not pulled");
  mux_hold_a: assert property (!(wr_acc && i_paddr == '0) [*3] |->
    $stable(o_mux_select_latch)) else $error("mux select moved");
  clear_cmd_a: assert property (wr_acc && o_pready &&
    i_paddr == 12'h010 && i_pwdata[0] |-> ##[1:3]
    (o_general_relay_latch == 14'h0000 && o_safety_relay_latch == 8'h00))
    else $error("clear command ignored");
  hv_enable_a: assert property (
    o_hv_supply_enable_n == !o_safety_relay_latch[6])
    else $error("supply enable wrong");
  cover property (o_pslverr);
  cover property (o_hv_fault_clear [*3]);
  cover property (o_link_cable_missing [*3]);
endmodule
bind rlsc_top rlsc_top_asserts #(.ADDR_W(ADDR_W)) u_chk (.i_clk_sys,
  .i_rstn, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready,
  .o_pslverr, .o_amp_present_n, .o_mux_select_latch, .o_general_relay_latch,
  .o_safety_relay_latch, .o_hv_supply_enable_n, .o_hv_fault_clear,
  .o_link_cable_missing);

// *** tb/rlsc_host_model.sv ***
// host side of the control cable: serial frames, cable supply, presence
`timescale 1ns/10ps
module rlsc_host_model
(
  // clock and bench control
  input  wire logic       i_clk_sys,
  input  wire logic       i_cable_on,
  input  wire logic       i_send,
  input  wire logic [7:0] i_byte,
  // cable side
  input  wire logic       i_amp_present_n,
  output logic            o_link_receive_line,
  output logic            o_link_cable_ok,
  output logic            o_host_sees_amp
);
  logic [9:0] frame = 10'h3ff;
  logic [1:0] tick  = 2'h0;
  logic       junk  = 1'b0;
  // each bit stands four clocks so the pin filter can pass it
  always @(posedge i_clk_sys)
  begin
    junk <= ~junk;
    if (i_send)
    begin
      frame <= {1'b1, i_byte, 1'b0};
      tick  <= 2'h0;
    end
    else
    begin
      tick <= tick + 2'h1;
      if (tick == 2'h3)
        frame <= {1'b1, frame[9:1]};
    end
  end
  // an unplugged line floats, so show a toggling level
  assign o_link_receive_line = i_cable_on ? frame[0] : junk;
  assign o_link_cable_ok     = i_cable_on;
  assign o_host_sees_amp     = i_cable_on && !i_amp_present_n;
endmodule

// *** tb/tb_relay_latch_safety_control.sv ***
// self-checking bench for the relay latch and safety control block
`timescale 1ns/10ps
module tb_relay_latch_safety_control;
  logic        i_clk_sys, i_rstn, i_psel, i_penable, i_pwrite;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd, r;
  logic [13:0] o_general_relay_latch, g;
  logic [7:0]  o_dac_code_latch, o_safety_relay_latch, s, tx_byte;
  logic [3:0]  o_mux_select_latch, o_band_relay_drive;
  logic [1:0]  o_direct_cal_relay;
  logic        o_pready, o_pslverr, err, i_link_receive_line, o_link_rx_data;
  logic        o_link_transmit_line, i_link_tx_data, o_amp_present_n;
  logic        i_link_cable_ok, i_hv_overcurrent, i_monitor_compare;
  logic        i_cal_enable_contact, o_monitor_compare_out, o_hv_shutdown;
  logic        o_precision_return_relay, o_sense_isolation_switch;
  logic        o_current_guard_relay, o_local_sense_relay_standby;
  logic        o_output_relay, o_remote_sense_relay, o_local_sense_relay;
  logic        o_amp_clamp_drive, o_hv_supply_enable_n, o_hv_fault_clear;
  logic        o_link_cable_missing, cable_on, send, sees, txp;
  logic [9:0]  frm;
  int          bad_count, samples_checked, seed, k;
  rlsc_top uut (.i_clk_sys, .i_rstn, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
    .i_link_receive_line, .o_link_transmit_line, .o_link_rx_data,
    .i_link_tx_data, .o_amp_present_n, .i_link_cable_ok, .i_hv_overcurrent,
    .i_monitor_compare, .i_cal_enable_contact, .o_mux_select_latch,
    .o_dac_code_latch, .o_monitor_compare_out, .o_precision_return_relay,
    .o_sense_isolation_switch, .o_general_relay_latch, .o_band_relay_drive,
    .o_current_guard_relay, .o_local_sense_relay_standby,
    .o_direct_cal_relay, .o_safety_relay_latch, .o_output_relay,
    .o_remote_sense_relay, .o_local_sense_relay, .o_amp_clamp_drive,
    .o_hv_supply_enable_n, .o_hv_shutdown, .o_hv_fault_clear,
    .o_link_cable_missing);
  rlsc_host_model host (.i_clk_sys, .i_cable_on(cable_on), .i_send(send),
    .i_byte(tx_byte), .i_amp_present_n(o_amp_present_n),
    .o_link_receive_line(i_link_receive_line),
    .o_link_cable_ok(i_link_cable_ok), .o_host_sees_amp(sees));
  initial
  begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge i_clk_sys);
    i_psel    <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite  <= w;
    i_paddr   <= a;
    i_pwdata  <= d;
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge i_clk_sys);
      n++;
    end
    while (o_pready !== 1'b1 && n < 20);
    rd = o_prdata;
    err = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
    if (o_pready !== 1'b1)
    begin
      bad_count++;
      complete_run();
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic done(input string t);
    $display("done %s", t);
  endtask
  // status word: compare, cable, cal enable, fault, clear held
  function automatic logic [31:0] st(logic c, logic e, logic h, logic k);
    return {27'h0, !k || h, h, e, k, c};
  endfunction
  initial
  begin
    seed = 9123;
    bad_count = 0;
    samples_checked = 0;
    {i_rstn, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
    {i_hv_overcurrent, i_monitor_compare, i_cal_enable_contact} = '0;
    {i_link_tx_data, cable_on, send, tx_byte} = {3'h6, 8'h00};
    repeat (4) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    wt(8);
    chk({o_general_relay_latch, o_safety_relay_latch}, 32'h0);
    chk(32'({o_hv_supply_enable_n, sees}), 32'h3);
    done("reset");
    for (k = 0; k < 6; k++)
    begin
      r = $random(seed);
      g = (k == 0) ? 14'h3fff : 14'($random(seed));
      s = (k == 0) ? 8'hff : 8'($random(seed));
      apb(1'b1, 12'h000, r);
      apb(1'b1, 12'h004, r);
      apb(1'b1, 12'h008, 32'(g));
      apb(1'b1, 12'h00c, 32'(s));
      wt(3);
      chk(32'({o_mux_select_latch, o_dac_code_latch}),
        32'({r[3:0], r[7:0]}));
      chk(32'(o_general_relay_latch), 32'(g));
      chk(32'({o_band_relay_drive,
        o_direct_cal_relay, o_local_sense_relay_standby,
        o_current_guard_relay}), 32'({g[13:10], g[3:0]}));
      chk(32'(o_safety_relay_latch), 32'(s));
      chk(32'({o_hv_supply_enable_n,
        o_amp_clamp_drive, o_sense_isolation_switch,
        o_precision_return_relay, o_local_sense_relay,
        o_remote_sense_relay, o_output_relay}), 32'({~s[6], s[5:0]}));
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, {28'h0, r[3:0]});
    end
    done("latches");
    apb(1'b1, 12'h010, 32'h1);
    wt(3);
    chk({o_general_relay_latch, o_safety_relay_latch}, 32'h0);
    chk(32'(o_mux_select_latch), 32'(r[3:0]));
    done("clear");
    for (k = 0; k < 4; k++)
    begin
      @(posedge i_clk_sys);
      i_monitor_compare <= 1'($random(seed));
      i_cal_enable_contact <= 1'($random(seed));
      wt(8);
      apb(1'b0, 12'h014, 32'h0);
      chk(rd,
        st(i_monitor_compare, i_cal_enable_contact, 0, 1));
      chk(32'(o_monitor_compare_out), 32'(i_monitor_compare));
    end
    done("status");
    apb(1'b1, 12'h00c, 32'h7f);
    i_hv_overcurrent <= 1'b1;
    wt(8);
    apb(1'b1, 12'h00c, 32'hff);
    wt(3);
    chk(32'({o_hv_shutdown, o_hv_fault_clear, o_safety_relay_latch}),
        32'h300);
    chk(32'(o_hv_supply_enable_n), 32'h1);
    @(posedge i_clk_sys);
    i_hv_overcurrent <= 1'b0;
    cable_on <= 1'b0;
    wt(8);
    chk(32'({o_link_cable_missing, o_safety_relay_latch}), 32'h100);
    apb(1'b0, 12'h014, 32'h0);
    chk(rd,
      st(i_monitor_compare, i_cal_enable_contact, 0, 0));
    @(posedge i_clk_sys);
    cable_on <= 1'b1;
    wt(8);
    apb(1'b1, 12'h00c, 32'h41);
    wt(3);
    chk(32'(o_safety_relay_latch), 32'h41);
    done("safety");
    apb(1'b0, 12'h018, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    done("unmapped");
    @(posedge i_clk_sys);
    frm = {1'b1, 8'($random(seed)), 1'b0};
    send    <= 1'b1;
    tx_byte <= frm[8:1];
    txp = i_link_tx_data;
    // rx shows each frame bit four clocks late; looked at mid-bit
    for (k = 0; k < 44; k++)
    begin
      @(posedge i_clk_sys);
      send           <= 1'b0;
      i_link_tx_data <= 1'($random(seed));
      #1;
      chk(32'(o_link_transmit_line), 32'(txp));
      txp = i_link_tx_data;
      if (k > 5 && k % 4 == 2)
        chk(32'(o_link_rx_data), 32'(frm[(k - 6) / 4]));
    end
    done("serial");
    complete_run();
  end
endmodule
